//--- logic/scc_supply_ctrl.sv
// Control of four per-channel supply converters: arms, clamp modes, learning, limits
// Overview of operation
// - Software selects any mix of the four converters with a select write.
// - Arm write enables positive and negative arm of each selected converter.
// - Negative arm off ties that channel's negative supply input to analog ground.
// - Voltage output: fixed 15.0 V symmetric rails unless clamp setting overrides.
// - Current output: rails follow range; negative rail only in bipolar 24 mA range, except with an open output.
// - Positive rail limit is 32 V, reduced to 26 V by high-side limit bit.
// - Clamp mode codes: 00 full tracking (reset), 01 fixed clamp, 10 learning.
// - Tracking keeps positive rail at least 4 V, negative at least 5 V, and the pin-side rail 3 V beyond the pin.
// - Fixed clamp: rail minimums follow four-bit positive and negative floor settings.
// - Learning senses current load and fixes the positive floor from it.
// - Learning completion loads positive floor and sets the learning done flag.
// - Positive floor is read-only while learning mode is active.
// - A fresh write of learning mode restarts the load sensing.
// - Open current output drives rails to fixed values per arm and pin polarity.
// - No load stops switching until load capacitor droops, then switching resumes.
// - Alarm output asserts when a converter reaches its high-side limit.
`timescale 1ns/100ps
module scc_supply_ctrl #(
  parameter int unsigned N_CH = scc_pkg::NUM_CH
) (
  input  wire logic                   clk_sys,
  input  wire logic                   rst_b,
  input  wire logic                   conv_sel_we,
  input  wire logic [N_CH-1:0]        conv_sel_d,
  input  wire logic                   arm_en_we,
  input  wire logic [N_CH-1:0]        pos_arm_d,
  input  wire logic [N_CH-1:0]        neg_arm_d,
  input  wire logic                   chan_sel_we,
  input  wire logic [N_CH-1:0]        chan_sel_d,
  input  wire logic                   clamp_we,
  input  wire logic [1:0]             clamp_mode_select_d,
  input  wire logic [3:0]             positive_floor_setting_d,
  input  wire logic [3:0]             negative_floor_setting_d,
  input  wire logic                   hs_limit_we,
  input  wire logic                   high_side_limit_select_d,
  input  wire logic [N_CH-1:0]        learning_done_clr,
  input  wire logic [N_CH-1:0]        out_is_current,
  input  wire logic [N_CH-1:0]        range_bipolar,
  input  wire logic [N_CH-1:0]        load_open,
  input  wire logic [N_CH-1:0]        load_none,
  input  wire logic [N_CH-1:0]        cap_droop_reached,
  input  wire logic [N_CH-1:0][8:0]   pin_level_dv,
  input  wire logic [N_CH-1:0]        pin_negative,
  input  wire logic [N_CH-1:0][3:0]   learned_floor,
  output logic [N_CH-1:0]             conv_sel_q,
  output logic [N_CH-1:0]             pos_arm_on_q,
  output logic [N_CH-1:0]             neg_arm_on_q,
  output logic [N_CH-1:0]             neg_to_ground_q,
  output logic [N_CH-1:0][1:0]        clamp_mode_select_q,
  output logic [N_CH-1:0][3:0]        positive_floor_setting_q,
  output logic [N_CH-1:0][3:0]        negative_floor_setting_q,
  output logic [N_CH-1:0]             high_side_limit_select_q,
  output logic [N_CH-1:0]             learning_done_flag_q,
  output logic [N_CH-1:0][8:0]        pos_target_dv_q,
  output logic [N_CH-1:0][8:0]        neg_target_dv_q,
  output logic [N_CH-1:0]             switching_q,
  output logic                        alarm_b_q
);
  import scc_pkg::*;

  typedef struct packed {
    logic [N_CH-1:0]             conv_sel;
    logic [N_CH-1:0]             pos_arm;
    logic [N_CH-1:0]             neg_arm;
    logic [N_CH-1:0]             pos_arm_on;
    logic [N_CH-1:0]             neg_arm_on;
    logic [N_CH-1:0]             chan_sel;
    scc_mode_t [N_CH-1:0]        mode;
    logic [N_CH-1:0][3:0]        pfloor;
    logic [N_CH-1:0][3:0]        nfloor;
    logic [N_CH-1:0]             hs_lim;
    logic [N_CH-1:0]             learn_busy;
    logic [N_CH-1:0][LCNT_W-1:0] learn_cnt;
    logic [N_CH-1:0]             done;
    logic [N_CH-1:0][8:0]        pos_tgt;
    logic [N_CH-1:0][8:0]        neg_tgt;
    logic [N_CH-1:0]             neg_gnd;
    logic [N_CH-1:0]             sw_on;
    logic                        alarm_b;
  } scc_state_t;

  scc_state_t st_q;
  scc_state_t st_d;

  function automatic logic [8:0] max9(input logic [8:0] a, input logic [8:0] b);
    max9 = (a > b) ? a : b;
  endfunction

  function automatic logic [8:0] floor_dv(input logic [3:0] code);
    floor_dv = 9'(V_FLOOR_BASE + 9'(code) * V_FLOOR_STEP);
  endfunction

  always_comb begin
    logic [8:0]      pos_raw;
    logic [8:0]      neg_raw;
    logic [8:0]      limit;
    logic [8:0]      track_p;
    logic [8:0]      track_n;
    logic            pos_on;
    logic            neg_on;
    logic [N_CH-1:0] at_limit;
    pos_raw  = '0;
    neg_raw  = '0;
    limit    = '0;
    track_p  = '0;
    track_n  = '0;
    pos_on   = 1'b0;
    neg_on   = 1'b0;
    at_limit = '0;
    st_d     = st_q;
    if (conv_sel_we) begin
      st_d.conv_sel = conv_sel_d;
    end
    if (chan_sel_we) begin
      st_d.chan_sel = chan_sel_d;
    end
    for (int c = 0; c < N_CH; c++) begin
      if (arm_en_we && st_q.conv_sel[c]) begin
        st_d.pos_arm[c] = pos_arm_d[c];
        st_d.neg_arm[c] = neg_arm_d[c];
      end
      // Gated copy kept in a flop so the arm outputs need no logic after it
      st_d.pos_arm_on[c] = st_d.conv_sel[c] & st_d.pos_arm[c];
      st_d.neg_arm_on[c] = st_d.conv_sel[c] & st_d.neg_arm[c];
      if (hs_limit_we && st_q.chan_sel[c]) begin
        st_d.hs_lim[c] = high_side_limit_select_d;
      end
      // Clear first, so a completion in the same cycle overrides it
      if (learning_done_clr[c]) begin
        st_d.done[c] = 1'b0;
      end
      // Reserved mode code is ignored rather than stored
      if (clamp_we && st_q.chan_sel[c] && clamp_mode_select_d != 2'(SCC_RSVD)) begin
        st_d.mode[c]   = scc_mode_t'(clamp_mode_select_d);
        st_d.nfloor[c] = negative_floor_setting_d;
        if (st_q.mode[c] != SCC_LEARN) begin
          st_d.pfloor[c] = positive_floor_setting_d;
        end
        if (clamp_mode_select_d == 2'(SCC_LEARN)) begin
          st_d.pfloor[c]     = st_q.pfloor[c];
          st_d.learn_busy[c] = 1'b1;
          st_d.learn_cnt[c]  = LCNT_W'(LEARN_CYC);
        end else begin
          st_d.learn_busy[c] = 1'b0;
        end
      end else if (st_q.learn_busy[c]) begin
        if (st_q.learn_cnt[c] == '0) begin
          st_d.learn_busy[c] = 1'b0;
          st_d.pfloor[c]     = learned_floor[c];
          st_d.done[c]       = 1'b1;
        end else begin
          st_d.learn_cnt[c] = st_q.learn_cnt[c] - 1'b1;
        end
      end
      pos_on  = st_q.conv_sel[c] & st_q.pos_arm[c];
      neg_on  = st_q.conv_sel[c] & st_q.neg_arm[c];
      limit   = st_q.hs_lim[c] ? V_HS_REDUCED : V_HS_DEFAULT;
      track_p = pin_negative[c] ? V_TRACK_MIN
                                : max9(V_TRACK_MIN, 9'(pin_level_dv[c] + V_HEADROOM));
      track_n = pin_negative[c] ? max9(V_NEG_MIN, 9'(pin_level_dv[c] + V_HEADROOM))
                                : V_NEG_MIN;
      if (!out_is_current[c]) begin
        pos_raw = V_VOUT_RAIL;
        neg_raw = V_VOUT_RAIL;
        if (st_q.mode[c] == SCC_FIXED) begin
          pos_raw = floor_dv(st_q.pfloor[c]);
          neg_raw = floor_dv(st_q.nfloor[c]);
        end
      end else if (load_open[c]) begin
        if (!neg_on) begin
          pos_raw = V_OC_POS_ONLY;
          neg_raw = V_OC_NEG_ONLY;
        end else if (pin_negative[c] && range_bipolar[c]) begin
          pos_raw = V_OC_POS_NEG;
          neg_raw = V_OC_NEG_NEG;
        end else begin
          pos_raw = V_OC_POS_BOTH;
          neg_raw = V_OC_NEG_BOTH;
        end
      end else begin
        case (st_q.mode[c])
          SCC_TRACK: begin
            pos_raw = track_p;
            neg_raw = track_n;
          end
          SCC_FIXED: begin
            pos_raw = max9(track_p, floor_dv(st_q.pfloor[c]));
            neg_raw = max9(track_n, floor_dv(st_q.nfloor[c]));
          end
          SCC_LEARN: begin
            // Tracking alone unless the learning done flag is set, then the positive floor applies too
            pos_raw = st_q.done[c] ? max9(track_p, floor_dv(st_q.pfloor[c])) : track_p;
            neg_raw = track_n;
          end
          default: begin
            pos_raw = track_p;
            neg_raw = track_n;
          end
        endcase
        if (!range_bipolar[c]) begin
          neg_raw = '0;
        end
      end
      at_limit[c]     = pos_on && (pos_raw >= limit);
      st_d.pos_tgt[c] = !pos_on ? 9'h000 : (at_limit[c] ? limit : pos_raw);
      st_d.neg_tgt[c] = neg_on ? neg_raw : 9'h000;
      st_d.neg_gnd[c] = !neg_on;
      // Stop on no load; droop of the load capacitor restarts switching
      st_d.sw_on[c]   = pos_on && (!load_none[c] || cap_droop_reached[c]);
    end
    st_d.alarm_b = ~|at_limit;
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st_q            <= '0;
      st_q.mode       <= '{default: SCC_TRACK};
      st_q.pfloor     <= {N_CH{RST_FLOOR}};
      st_q.nfloor     <= {N_CH{RST_FLOOR}};
      st_q.hs_lim     <= {N_CH{RST_HS_LIMIT}};
      st_q.neg_gnd    <= '1;
      st_q.alarm_b    <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  always_comb begin
    for (int c = 0; c < N_CH; c++) begin
      clamp_mode_select_q[c] = 2'(st_q.mode[c]);
    end
  end
  assign conv_sel_q               = st_q.conv_sel;
  assign pos_arm_on_q             = st_q.pos_arm_on;
  assign neg_arm_on_q             = st_q.neg_arm_on;
  assign neg_to_ground_q          = st_q.neg_gnd;
  assign positive_floor_setting_q = st_q.pfloor;
  assign negative_floor_setting_q = st_q.nfloor;
  assign high_side_limit_select_q = st_q.hs_lim;
  assign learning_done_flag_q     = st_q.done;
  assign pos_target_dv_q          = st_q.pos_tgt;
  assign neg_target_dv_q          = st_q.neg_tgt;
  assign switching_q              = st_q.sw_on;
  assign alarm_b_q                = st_q.alarm_b;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  a_sel_write: assert property (conv_sel_we |=> conv_sel_q == $past(conv_sel_d))
    else $error("converter select not stored");
  a_neg_ground: assert property (neg_to_ground_q[0] |-> neg_target_dv_q[0] == 9'h000)
    else $error("negative rail driven while grounded");
  // Limit in force is the one registered a cycle before the target
  a_hs_cap: assert property (
    pos_target_dv_q[1] <= ($past(high_side_limit_select_q[1]) ? V_HS_REDUCED : V_HS_DEFAULT))
    else $error("positive rail above high-side limit");
  a_alarm_lim: assert property (!alarm_b_q |-> $past(pos_arm_on_q) != '0)
    else $error("alarm without an enabled positive arm");
  a_arm_write: assert property (
    arm_en_we && !conv_sel_we && conv_sel_q[0]
    |=> pos_arm_on_q[0] == $past(pos_arm_d[0]) && neg_arm_on_q[0] == $past(neg_arm_d[0]))
    else $error("arm enable not stored for a selected converter");
  a_floor_lock: assert property (
    clamp_mode_select_q[0] == 2'(SCC_LEARN) && !st_q.learn_busy[0]
    |=> $stable(positive_floor_setting_q[0]))
    else $error("positive floor changed in learning mode");
  a_reserved_mode: assert property (
    clamp_we && clamp_mode_select_d == 2'(SCC_RSVD) |=> $stable(clamp_mode_select_q))
    else $error("reserved clamp mode was stored");
  a_learn_done: assert property (
    st_q.learn_busy[0] && st_q.learn_cnt[0] == '0 && !clamp_we
    |=> learning_done_flag_q[0] && positive_floor_setting_q[0] == $past(learned_floor[0]))
    else $error("learning completion not recorded");
  a_learn_start: assert property (
    clamp_we && clamp_mode_select_d == 2'(SCC_LEARN) && st_q.chan_sel[0]
    |=> st_q.learn_busy[0])
    else $error("learning pass not restarted");
  a_voltage_rail: assert property (
    !out_is_current[0] && pos_arm_on_q[0] && neg_arm_on_q[0]
    && clamp_mode_select_q[0] == 2'(SCC_TRACK)
    |=> pos_target_dv_q[0] == V_VOUT_RAIL && neg_target_dv_q[0] == V_VOUT_RAIL)
    else $error("voltage output rails not at fixed level");
  a_unipolar_neg: assert property (
    out_is_current[0] && !range_bipolar[0] && !load_open[0] |=> neg_target_dv_q[0] == 9'h000)
    else $error("negative rail outside bipolar range");
  a_track_min: assert property (
    conv_sel_q[0] && pos_arm_on_q[0] && out_is_current[0]
    && !load_open[0] && clamp_mode_select_q[0] == 2'(SCC_TRACK)
    |=> pos_target_dv_q[0] >= V_TRACK_MIN)
    else $error("tracking rail below minimum");
  a_no_load: assert property (load_none[0] && !cap_droop_reached[0] |=> !switching_q[0])
    else $error("switching under no load before droop");

  // Channels share one loop body, so checks on one channel stand for all
  c_learn_pass: cover property (st_q.learn_busy[0] ##1 learning_done_flag_q[0]);
  c_alarm: cover property (!alarm_b_q);
  c_open_load: cover property (load_open[0] && pos_arm_on_q[0] ##1 pos_target_dv_q[0] != 9'h000);
  c_fixed_mode: cover property (clamp_mode_select_q[1] == 2'(SCC_FIXED));
  c_switch_resume: cover property (!switching_q[0] ##1 switching_q[0]);
endmodule

//--- logic/scc_pkg.sv
// Constants and types shared by the supply converter clamp control block
package scc_pkg;
  localparam int unsigned NUM_CH        = 4;
  localparam int unsigned DV_W          = 9;
  // Clock period for turning times into cycle counts
  localparam int unsigned CLK_PERIOD_NS = 100;
  // Load sensing time of one learning pass
  localparam int unsigned LEARN_TIME_NS = 10000;
  localparam int unsigned LEARN_CYC     = (LEARN_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned LCNT_W        = 8;
  // Rail levels in units of 0.1 V
  localparam logic [8:0] V_VOUT_RAIL    = 9'h096;
  localparam logic [8:0] V_TRACK_MIN    = 9'h028;
  localparam logic [8:0] V_HEADROOM     = 9'h01E;
  localparam logic [8:0] V_NEG_MIN      = 9'h032;
  localparam logic [8:0] V_HS_DEFAULT   = 9'h140;
  localparam logic [8:0] V_HS_REDUCED   = 9'h104;
  localparam logic [8:0] V_OC_POS_BOTH  = 9'h0C8;
  localparam logic [8:0] V_OC_NEG_BOTH  = 9'h032;
  localparam logic [8:0] V_OC_POS_NEG   = 9'h028;
  localparam logic [8:0] V_OC_NEG_NEG   = 9'h0C8;
  localparam logic [8:0] V_OC_POS_ONLY  = 9'h140;
  localparam logic [8:0] V_OC_NEG_ONLY  = 9'h000;
  // Floor setting code to rail level
  localparam logic [8:0] V_FLOOR_BASE   = 9'h028;
  localparam logic [8:0] V_FLOOR_STEP   = 9'h014;
  // Reset values
  localparam logic [3:0] RST_FLOOR      = 4'h0;
  localparam logic       RST_HS_LIMIT   = 1'b0;
  typedef enum logic [1:0] {
    SCC_TRACK,
    SCC_FIXED,
    SCC_LEARN,
    SCC_RSVD
  } scc_mode_t;
endpackage

//--- bench/scc_host_model.sv
// Host model issuing register writes to the supply converter control
`timescale 1ns/100ps
module scc_host_model (
  input  wire logic       clk_sys,
  output logic            conv_sel_we,
  output logic [3:0]      conv_sel_d,
  output logic            arm_en_we,
  output logic [3:0]      pos_arm_d,
  output logic [3:0]      neg_arm_d,
  output logic            chan_sel_we,
  output logic [3:0]      chan_sel_d,
  output logic            clamp_we,
  output logic [1:0]      clamp_mode_select_d,
  output logic [3:0]      positive_floor_setting_d,
  output logic [3:0]      negative_floor_setting_d,
  output logic            hs_limit_we,
  output logic            high_side_limit_select_d
);
  initial begin
    {hs_limit_we, clamp_we, chan_sel_we, arm_en_we, conv_sel_we} = 5'h00;
    {conv_sel_d, pos_arm_d, neg_arm_d, chan_sel_d} = 16'h0000;
    {positive_floor_setting_d, negative_floor_setting_d} = 8'h00;
    clamp_mode_select_d = 2'h0;
    high_side_limit_select_d = 1'b0;
  end
  // Data is set while strobes are low, so it is steady while a strobe is high
  task automatic wr(input int k);
    @(negedge clk_sys);
    {hs_limit_we, clamp_we, chan_sel_we, arm_en_we, conv_sel_we} = 5'h01 << k;
    @(negedge clk_sys);
    {hs_limit_we, clamp_we, chan_sel_we, arm_en_we, conv_sel_we} = 5'h00;
  endtask
  task automatic wr_conv(input logic [3:0] m);
    conv_sel_d = m;
    wr(0);
  endtask
  task automatic wr_arm(input logic [3:0] p, input logic [3:0] n);
    pos_arm_d = p;
    neg_arm_d = n;
    wr(1);
  endtask
  task automatic wr_chan(input logic [3:0] m);
    chan_sel_d = m;
    wr(2);
  endtask
  task automatic wr_clamp(input logic [1:0] md, input logic [3:0] pf, input logic [3:0] nf);
    clamp_mode_select_d = md;
    positive_floor_setting_d = pf;
    negative_floor_setting_d = nf;
    wr(3);
  endtask
  task automatic wr_hs(input logic [3:0] m, input logic b);
    wr_chan(m);
    high_side_limit_select_d = b;
    wr(4);
  endtask
  // Tracking first, then learning; the bench has the current output running
  task automatic start_learn(input logic [3:0] m);
    wr_chan(m);
    wr_clamp(2'h0, 4'h0, 4'h0);
    wr_clamp(2'h2, 4'h0, 4'h0);
  endtask
endmodule

//--- bench/scc_supply_ctrl_bench.sv
// Self-checking bench for the supply converter clamp control
`timescale 1ns/100ps
module scc_supply_ctrl_bench;
  import scc_pkg::*;
  logic            clk_sys = 1'b0;
  logic            rst_b;
  logic            conv_sel_we, arm_en_we, chan_sel_we, clamp_we, hs_limit_we;
  logic            high_side_limit_select_d, alarm_b_q;
  logic [1:0]      clamp_mode_select_d;
  logic [3:0]      conv_sel_d, pos_arm_d, neg_arm_d, chan_sel_d;
  logic [3:0]      positive_floor_setting_d, negative_floor_setting_d;
  logic [3:0]      learning_done_clr, out_is_current, range_bipolar, load_open;
  logic [3:0]      load_none, cap_droop_reached, pin_negative;
  logic [3:0][8:0] pin_level_dv, pos_target_dv_q, neg_target_dv_q;
  logic [3:0][3:0] learned_floor, positive_floor_setting_q, negative_floor_setting_q;
  logic [3:0][1:0] clamp_mode_select_q;
  logic [3:0]      conv_sel_q, pos_arm_on_q, neg_arm_on_q, neg_to_ground_q;
  logic [3:0]      high_side_limit_select_q, learning_done_flag_q, switching_q;
  int              failures = 0;
  int              compares = 0;
  int              n;
  always #50 clk_sys = ~clk_sys;
  scc_host_model HOST (.clk_sys, .conv_sel_we, .conv_sel_d, .arm_en_we, .pos_arm_d,
    .neg_arm_d, .chan_sel_we, .chan_sel_d, .clamp_we, .clamp_mode_select_d,
    .positive_floor_setting_d, .negative_floor_setting_d, .hs_limit_we,
    .high_side_limit_select_d);
  scc_supply_ctrl DUT (.clk_sys, .rst_b, .conv_sel_we, .conv_sel_d, .arm_en_we, .pos_arm_d,
    .neg_arm_d, .chan_sel_we, .chan_sel_d, .clamp_we, .clamp_mode_select_d,
    .positive_floor_setting_d, .negative_floor_setting_d, .hs_limit_we,
    .high_side_limit_select_d, .learning_done_clr, .out_is_current, .range_bipolar,
    .load_open, .load_none, .cap_droop_reached, .pin_level_dv, .pin_negative,
    .learned_floor, .conv_sel_q, .pos_arm_on_q, .neg_arm_on_q, .neg_to_ground_q,
    .clamp_mode_select_q, .positive_floor_setting_q, .negative_floor_setting_q,
    .high_side_limit_select_q, .learning_done_flag_q, .pos_target_dv_q,
    .neg_target_dv_q, .switching_q, .alarm_b_q);
  task automatic tally_and_finish();
    if (failures == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic step(input int k);
    repeat (k) @(negedge clk_sys);
  endtask
  // Bounded wait for channel 0 learning to finish
  task automatic wait_done(output int cnt);
    cnt = 0;
    while (learning_done_flag_q[0] !== 1'b1) begin
      step(1);
      cnt++;
      if (cnt > 300) begin
        failures++;
        $display("mismatch %0t learning never completed", $time);
        tally_and_finish();
      end
    end
  endtask
  task automatic t_reset();
    chk(neg_to_ground_q, 9'h00F);
    chk(clamp_mode_select_q, 9'h000);
    chk(high_side_limit_select_q, 9'h000);
    chk({conv_sel_q, pos_arm_on_q}, 9'h000);
    chk(alarm_b_q, 9'h001);
  endtask
  task automatic t_arms();
    HOST.wr_conv(4'h3);
    HOST.wr_arm(4'hF, 4'h5);
    step(1);
    chk(conv_sel_q, 9'h003);
    chk(pos_arm_on_q, 9'h003);
    chk(neg_arm_on_q, 9'h001);
    chk(neg_to_ground_q, 9'h00E);
    HOST.wr_conv(4'hF);
    HOST.wr_arm(4'hF, 4'hD);
    step(1);
    chk(neg_to_ground_q, 9'h002);
  endtask
  task automatic t_voltage();
    chk(pos_target_dv_q[0], V_VOUT_RAIL);
    chk(neg_target_dv_q[0], V_VOUT_RAIL);
    HOST.wr_chan(4'h1);
    HOST.wr_clamp(2'h1, 4'h3, 4'h5);
    step(1);
    chk(clamp_mode_select_q, 9'h001);
    chk(pos_target_dv_q[0], 9'h064);
    chk(neg_target_dv_q[0], 9'h08C);
    chk(negative_floor_setting_q[0], 9'h005);
    // Reserved code must leave mode and positive floor untouched
    HOST.wr_clamp(2'h3, 4'h9, 4'h9);
    step(1);
    chk({clamp_mode_select_q[0], positive_floor_setting_q[0]}, 9'h013);
    HOST.wr_clamp(2'h0, 4'h0, 4'h0);
  endtask
  task automatic t_current();
    out_is_current = 4'h1;
    pin_level_dv[0] = 9'h064;
    step(2);
    chk(pos_target_dv_q[0], 9'h082);
    chk(neg_target_dv_q[0], 9'h000);
    range_bipolar = 4'h1;
    pin_negative = 4'h1;
    step(2);
    chk(pos_target_dv_q[0], V_TRACK_MIN);
    chk(neg_target_dv_q[0], 9'h082);
  endtask
  task automatic t_open();
    range_bipolar = 4'h0;
    pin_negative = 4'h0;
    out_is_current = 4'h3;
    load_open = 4'h3;
    step(2);
    chk(pos_target_dv_q[0], V_OC_POS_BOTH);
    chk(neg_target_dv_q[0], V_OC_NEG_BOTH);
    chk(pos_target_dv_q[1], V_OC_POS_ONLY);
    chk(neg_target_dv_q[1], V_OC_NEG_ONLY);
    chk(alarm_b_q, 9'h000);
    range_bipolar = 4'h1;
    pin_negative = 4'h1;
    step(2);
    chk(pos_target_dv_q[0], V_OC_POS_NEG);
    chk(neg_target_dv_q[0], V_OC_NEG_NEG);
    HOST.wr_hs(4'h2, 1'b1);
    step(1);
    chk(high_side_limit_select_q, 9'h002);
    chk(pos_target_dv_q[1], V_HS_REDUCED);
    chk(alarm_b_q, 9'h000);
    {load_open, range_bipolar, pin_negative} = 12'h000;
    step(2);
    chk(alarm_b_q, 9'h001);
  endtask
  task automatic t_switch();
    load_none = 4'h1;
    step(2);
    chk(switching_q[0], 9'h000);
    cap_droop_reached = 4'h1;
    step(2);
    chk(switching_q[0], 9'h001);
    {load_none, cap_droop_reached} = 8'h00;
  endtask
  task automatic t_learn();
    out_is_current = 4'h1;
    learned_floor[0] = 4'h6;
    HOST.start_learn(4'h1);
    wait_done(n);
    chk(n >= LEARN_CYC - 2 && n <= LEARN_CYC + 3, 9'h001);
    chk(positive_floor_setting_q[0], 9'h006);
    learning_done_clr = 4'h1;
    step(1);
    learning_done_clr = 4'h0;
    step(1);
    chk(learning_done_flag_q, 9'h000);
    // Rewrite of learning with a floor value: pass restarts, floor stays
    learned_floor[0] = 4'h9;
    HOST.wr_clamp(2'h2, 4'h2, 4'h0);
    step(1);
    chk(positive_floor_setting_q[0], 9'h006);
    wait_done(n);
    chk(n >= LEARN_CYC - 3 && n <= LEARN_CYC + 3, 9'h001);
    chk({clamp_mode_select_q[0], positive_floor_setting_q[0]}, 9'h029);
  endtask
  initial begin
    rst_b = 1'b0;
    {learning_done_clr, out_is_current, range_bipolar, load_open} = 16'h0000;
    {load_none, cap_droop_reached, pin_negative} = 12'h000;
    pin_level_dv = '0;
    learned_floor = '0;
    step(6);
    rst_b = 1'b1;
    t_reset();
    t_arms();
    t_voltage();
    t_current();
    t_open();
    t_switch();
    t_learn();
    tally_and_finish();
  end
endmodule
